// File: rtl/temp_delay_host.sv
// Host end: triggers a conversion, times the response edge and converts it to Celsius.
module temp_delay_host
  import temp_delay_pkg::*;
#(
  parameter int RESET_CYC_P = RESET_CYC,
  parameter int READY_US_P  = READY_US
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  temp_wire_if.host         wire_if,
  input  wire logic         start_i,
  input  wire logic         force_ready_i,
  input  wire logic         high_range_i,
  input  wire logic         delay_select_msb_i,
  input  wire logic         delay_select_lsb_i,
  output logic              busy_o,
  output logic              done_o,
  output logic              timeout_o,
  output logic [US_W-1:0]   delay_us_o,
  output logic [15:0]       temp_c_x100_o
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_START,
    H_REL,
    H_MEASURE,
    H_DIV,
    H_FIN,
    H_RESET
  } host_state_t;

  localparam logic [PRE_W-1:0] PRE_LAST   = PRE_W'(CLK_MHZ - 1);
  localparam logic [CYC_W-1:0] SETUP_LAST = CYC_W'(SETUP_CYC - 1);
  localparam logic [CYC_W-1:0] START_LAST = CYC_W'(START_CYC - 1);
  localparam logic [CYC_W-1:0] RESET_LAST = CYC_W'(RESET_CYC_P - 1);
  localparam logic [US_W-1:0]  READY_LIM  = US_W'(READY_US_P);
  localparam logic [4:0]       DIV_LAST   = 5'h19;

  host_state_t       state;
  logic [CYC_W-1:0]  cyc;
  logic [PRE_W-1:0]  pre_cnt;
  logic [US_W-1:0]   us_cnt;
  logic              drive;
  logic [25:0]       num;
  logic [25:0]       quo;
  logic [MULT_W:0]   rem;
  logic [MULT_W-1:0] den;
  logic [4:0]        bit_cnt;
  logic [MULT_W:0]   rem_sh;
  logic              ge;
  logic [MULT_W:0]   next_rem;
  logic [17:0]       next_temp;

  // The host only ever sinks the wire; the pull-up restores the high level.
  assign wire_if.host_out = 1'b0;
  assign wire_if.host_oe  = drive;
  assign busy_o           = (state != H_IDLE);

  // ==========================================================================
  // Free-running microsecond counter, zeroed at the trigger edge
  // ==========================================================================

  // Held at zero through setup, so time zero is the edge that pulls the wire low.
  always_ff @(posedge mclk_i) begin
    if (reset_i || state == H_SETUP) begin
      pre_cnt <= '0;
      us_cnt  <= '0;
    end else if (pre_cnt == PRE_LAST) begin
      pre_cnt <= '0;
      us_cnt  <= us_cnt + US_W'(1);
    end else begin
      pre_cnt <= pre_cnt + PRE_W'(1);
    end
  end

  // ==========================================================================
  // Restoring divider step: delay x 100 over the multiplier
  // ==========================================================================

  // One quotient bit a cycle keeps the divider small at the cost of latency.
  always_comb begin
    rem_sh    = {rem[MULT_W-1:0], num[25]};
    ge        = (rem_sh >= {1'b0, den});
    next_rem  = ge ? (rem_sh - {1'b0, den}) : rem_sh;
    next_temp = {1'b0, quo[16:0]} - 18'(KELVIN_X100);
  end

  // ==========================================================================
  // Transfer sequence
  // ==========================================================================

  // Only the first falling edge after release is timed, so the chosen
  // multiplier must belong to the earliest sensor on a shared wire.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state         <= H_IDLE;
      cyc           <= '0;
      drive         <= 1'b0;
      done_o        <= 1'b0;
      timeout_o     <= 1'b0;
      delay_us_o    <= '0;
      temp_c_x100_o <= '0;
      num           <= '0;
      quo           <= '0;
      rem           <= '0;
      den           <= '0;
      bit_cnt       <= '0;
    end else begin
      done_o <= 1'b0;
      case (state)
        H_IDLE: begin
          cyc <= '0;
          if (force_ready_i) begin
            state <= H_RESET;
            drive <= 1'b1;
          end else if (start_i) begin
            state <= H_SETUP;
            // Distinct, non-overlapping multipliers per wire are a board choice.
            den   <= mult_us_per_k(high_range_i, {delay_select_msb_i, delay_select_lsb_i});
          end
        end
        H_SETUP: begin
          // The wire must stand high without a break before the start pulse.
          if (!wire_if.line) begin
            cyc <= '0;
          end else if (cyc == SETUP_LAST) begin
            cyc   <= '0;
            drive <= 1'b1;
            state <= H_START;
          end else begin
            cyc <= cyc + CYC_W'(1);
          end
        end
        H_START: begin
          // Minimum width, far below the longest allowed start pulse.
          if (cyc == START_LAST) begin
            drive <= 1'b0;
            state <= H_REL;
          end else begin
            cyc <= cyc + CYC_W'(1);
          end
        end
        H_REL: begin
          if (wire_if.line) begin
            state <= H_MEASURE;
          end
        end
        H_MEASURE: begin
          if (!wire_if.line) begin
            delay_us_o <= us_cnt;
            timeout_o  <= 1'b0;
            num        <= 26'(us_cnt) * 26'(SCALE_X100);
            rem        <= '0;
            quo        <= '0;
            bit_cnt    <= '0;
            state      <= H_DIV;
          end else if (us_cnt >= READY_LIM) begin
            timeout_o <= 1'b1;
            done_o    <= 1'b1;
            state     <= H_IDLE;
          end
        end
        H_DIV: begin
          rem     <= next_rem;
          quo     <= {quo[24:0], ge};
          num     <= {num[24:0], 1'b0};
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == DIV_LAST) begin
            state <= H_FIN;
          end
        end
        H_FIN: begin
          temp_c_x100_o <= next_temp[15:0];
          done_o        <= 1'b1;
          state         <= H_IDLE;
        end
        H_RESET: begin
          // A long low returns every sensor on the wire to ready.
          if (cyc == RESET_LAST) begin
            drive <= 1'b0;
            done_o <= 1'b1;
            state <= H_IDLE;
          end else begin
            cyc <= cyc + CYC_W'(1);
          end
        end
        default: begin
          state <= H_IDLE;
          drive <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: rtl/temp_delay_pkg.sv
// Shared constants, timing counts and multiplier decode for the single-wire temperature-to-delay link.
package temp_delay_pkg;

  // ==========================================================================
  // Clock and field widths
  // ==========================================================================
  localparam int CLK_MHZ = 200;           // System clock rate in MHz.
  localparam int TEMP_W  = 9;             // Temperature in whole kelvin.
  localparam int MULT_W  = 10;            // Multiplier in us per kelvin.
  localparam int US_W    = 20;            // Microsecond counters.
  localparam int CYC_W   = 27;            // Cycle counters up to the ready timeout.
  localparam int PRE_W   = 8;             // Prescaler from cycles to microseconds.

  // ==========================================================================
  // Times in their own units and the cycle counts derived from them
  // ==========================================================================
  localparam int GLITCH_NS    = 500;
  localparam int GLITCH_CYC   = (GLITCH_NS * CLK_MHZ) / 1000;
  localparam int RESET_MS     = 16;
  localparam int RESET_CYC    = RESET_MS * 1000 * CLK_MHZ;
  localparam int READY_MS     = 520;
  localparam int READY_CYC    = READY_MS * 1000 * CLK_MHZ;
  localparam int READY_US     = READY_MS * 1000;
  localparam int SETUP_US     = 10;
  localparam int SETUP_CYC    = SETUP_US * CLK_MHZ;
  localparam int START_NS     = 2500;
  localparam int START_CYC    = (START_NS * CLK_MHZ + 999) / 1000;
  localparam int START_MAX_MS = 1;
  localparam int START_MAX_CYC = START_MAX_MS * 1000 * CLK_MHZ;

  // ==========================================================================
  // Conversion figures
  // ==========================================================================
  localparam int LOW_US_PER_K = 5;        // Response pulse length per kelvin.
  localparam int SCALE_X100   = 100;      // Result is in hundredths of a degree.
  localparam int KELVIN_X100  = 27315;    // Kelvin to Celsius offset, hundredths.

  // Multiplier in us per kelvin from the range variant and the two straps.
  function automatic logic [MULT_W-1:0] mult_us_per_k(input logic high, input logic [1:0] sel);
    logic [MULT_W-1:0] m;
    m = 10'h005;
    case ({high, sel})
      3'h0:    m = 10'h005;
      3'h1:    m = 10'h014;
      3'h2:    m = 10'h028;
      3'h3:    m = 10'h050;
      3'h4:    m = 10'h0a0;
      3'h5:    m = 10'h140;
      3'h6:    m = 10'h1e0;
      default: m = 10'h280;
    endcase
    return m;
  endfunction

endpackage

// File: rtl/temp_wire_if.sv
// Shared open-drain wire between the sensor end and the host end.
interface temp_wire_if;
  logic dev_out;   // Sensor output value, always low.
  logic dev_oe;    // Sensor drives the wire.
  logic host_out;  // Host output value, always low.
  logic host_oe;   // Host drives the wire.
  logic line;      // Resolved wire level with the pull-up.

  // The pull-up holds the wire high unless an enabled driver sinks it.
  assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

  modport device (input line, output dev_out, output dev_oe);
  modport host (input line, output host_out, output host_oe);
endinterface

// File: rtl/temp_delay_sensor.sv
// Sensor end: converts a temperature into a delayed low pulse on the shared wire.
module temp_delay_sensor
  import temp_delay_pkg::*;
#(
  parameter int RESET_CYC_P = RESET_CYC,
  parameter int READY_CYC_P = READY_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  temp_wire_if.device            wire_if,
  input  wire logic [TEMP_W-1:0] temp_kelvin_i,
  input  wire logic              high_range_i,
  input  wire logic              delay_select_msb_i,
  input  wire logic              delay_select_lsb_i,
  output logic                   ready_o
);

  typedef enum logic [2:0] {
    ST_READY,
    ST_TRIG,
    ST_DELAY,
    ST_RESP,
    ST_WAIT
  } dev_state_t;

  localparam logic [6:0]       GLITCH_LAST = 7'(GLITCH_CYC - 1);
  localparam logic [PRE_W-1:0] PRE_LAST    = PRE_W'(CLK_MHZ - 1);
  localparam logic [PRE_W-1:0] PRE_START   = PRE_W'(GLITCH_CYC);
  localparam logic [CYC_W-1:0] CYC_START   = CYC_W'(GLITCH_CYC);
  localparam logic [CYC_W-1:0] READY_LAST  = CYC_W'(READY_CYC_P - 1);
  localparam logic [22:0]      RESET_LAST  = 23'(RESET_CYC_P - 1);

  dev_state_t        state;
  logic              line_f;
  logic [6:0]        glitch_cnt;
  logic              fall_f;
  logic [1:0]        sel;
  logic [PRE_W-1:0]  pre_cnt;
  logic [US_W-1:0]   us_cnt;
  logic [CYC_W-1:0]  since_trig;
  logic [22:0]       low_cnt;
  logic [US_W-1:0]   resp_at;
  logic [US_W-1:0]   rel_at;
  logic              drive;
  logic              timed_out;
  logic              forced;
  logic [US_W-1:0]   next_resp_at;
  logic [US_W-1:0]   next_rel_at;

  // ==========================================================================
  // Wire output
  // ==========================================================================

  // The pin only ever sinks; the pull-up restores the high level.
  assign wire_if.dev_out = 1'b0;
  assign wire_if.dev_oe  = drive;
  assign ready_o         = (state == ST_READY);

  // ==========================================================================
  // Glitch filter
  // ==========================================================================

  // A level change is accepted only after it has stood for the glitch time.
  // The price is that every accepted edge is seen that many cycles late,
  // which the time base below makes up for at the trigger edge.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      line_f     <= 1'b1;
      glitch_cnt <= 7'h00;
    end else if (wire_if.line == line_f) begin
      glitch_cnt <= 7'h00;
    end else if (glitch_cnt == GLITCH_LAST) begin
      line_f     <= wire_if.line;
      glitch_cnt <= 7'h00;
    end else begin
      glitch_cnt <= glitch_cnt + 7'h01;
    end
  end

  // A filtered falling edge is about to be accepted this cycle.
  assign fall_f = line_f && !wire_if.line && (glitch_cnt == GLITCH_LAST);

  // ==========================================================================
  // Strap capture
  // ==========================================================================

  // Straps are tied off, so they are simply sampled while idle; a change
  // during a conversion has no effect until the next trigger.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sel <= 2'h0;
    end else if (state == ST_READY) begin
      sel <= {delay_select_msb_i, delay_select_lsb_i};
    end
  end

  // ==========================================================================
  // Response targets
  // ==========================================================================

  // Targets in microseconds after the trigger edge, from temperature and multiplier.
  always_comb begin
    next_resp_at = US_W'(mult_us_per_k(high_range_i, sel)) * US_W'(temp_kelvin_i);
    next_rel_at  = next_resp_at + US_W'(LOW_US_PER_K) * US_W'(temp_kelvin_i);
  end

  // Temperature is frozen at the trigger so a drifting input cannot move the pulse.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      resp_at <= '0;
      rel_at  <= '0;
    end else if (state == ST_READY && fall_f) begin
      resp_at <= next_resp_at;
      rel_at  <= next_rel_at;
    end
  end

  // ==========================================================================
  // Time base, the thermal oscillator stand-in
  // ==========================================================================

  // The prescaler and since_trig are preloaded with the filter latency, and us_cnt is cleared, so that time is
  // measured from the raw falling edge, not from the filtered one.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pre_cnt    <= '0;
      us_cnt     <= '0;
      since_trig <= '0;
    end else if (state == ST_READY) begin
      if (fall_f) begin
        pre_cnt    <= PRE_START;
        us_cnt     <= '0;
        since_trig <= CYC_START;
      end
    end else begin
      since_trig <= since_trig + CYC_W'(1);
      if (pre_cnt == PRE_LAST) begin
        pre_cnt <= '0;
        us_cnt  <= us_cnt + US_W'(1);
      end else begin
        pre_cnt <= pre_cnt + PRE_W'(1);
      end
    end
  end

  // ==========================================================================
  // Forced and automatic return to ready
  // ==========================================================================

  // Only a low that someone else holds counts toward a forced return; our
  // own response pulse is far shorter anyway but is kept out on principle.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      low_cnt <= '0;
    end else if (line_f || drive) begin
      low_cnt <= '0;
    end else if (low_cnt != RESET_LAST) begin
      low_cnt <= low_cnt + 23'h000001;
    end
  end

  assign forced    = (low_cnt == RESET_LAST);
  assign timed_out = (state != ST_READY) && (since_trig >= READY_LAST);

  // ==========================================================================
  // Conversion sequence
  // ==========================================================================

  // Reset lands in ready; a forced low or the timeout overrides any phase.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= ST_READY;
      drive <= 1'b0;
    end else if (state != ST_READY && (forced || timed_out)) begin
      state <= ST_READY;
      drive <= 1'b0;
    end else begin
      case (state)
        ST_READY: begin
          if (fall_f) begin
            state <= ST_TRIG;
          end
        end
        ST_TRIG: begin
          // Wait for the host to let go; the wire is ours afterwards.
          if (line_f) begin
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (us_cnt >= resp_at) begin
            state <= ST_RESP;
            drive <= 1'b1;
          end
        end
        ST_RESP: begin
          if (us_cnt >= rel_at) begin
            state <= ST_WAIT;
            drive <= 1'b0;
          end
        end
        ST_WAIT: begin
          // Idle until the timeout or a forced low returns us to ready.
          state <= ST_WAIT;
        end
        default: begin
          state <= ST_READY;
          drive <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: test/temp_wire_sva.sv
// Concurrent checks on the shared single-wire link between the sensor end and the host end.
module temp_wire_sva
  import temp_delay_pkg::*;
#(
  parameter int T_K     = 1,
  parameter int RST_CYC = 2000
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LOW_CYC = LOW_US_PER_K * T_K * CLK_MHZ;
  localparam int MULTS [8] = '{5, 20, 40, 80, 160, 320, 480, 640};

  logic [31:0] since_trig;
  logic [31:0] hi_len;
  logic [31:0] pulse_len;
  logic [31:0] resp_len;
  logic [31:0] setup_seen;
  logic        host_oe_q;

  // ==========================================================================
  // Helper counters
  // ==========================================================================
  // Host pulse bookkeeping; setup is latched at the start so it can still be checked at release, when hi_len is back at zero.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      host_oe_q  <= 1'b0;
      since_trig <= '0;
      pulse_len  <= '0;
      setup_seen <= '0;
    end else begin
      host_oe_q  <= host_oe;
      since_trig <= (host_oe && !host_oe_q) ? 32'h1 : since_trig + 32'h1;
      pulse_len  <= host_oe ? pulse_len + 32'h1 : '0;
      if (host_oe && !host_oe_q) begin
        setup_seen <= hi_len;
      end
    end
  end

  // Wire high time and sensor pulse length.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hi_len   <= '0;
      resp_len <= '0;
    end else begin
      hi_len   <= line ? hi_len + 32'h1 : '0;
      resp_len <= dev_oe ? resp_len + 32'h1 : '0;
    end
  end

  // The checker cannot see the straps, so any legal multiplier is accepted, with a few cycles of edge lag.
  function automatic logic delay_ok(input logic [31:0] cyc);
    logic ok;
    int   m;
    ok = 1'b0;
    for (int i = 0; i < 8; i++) begin
      m = MULTS[i] * T_K * CLK_MHZ;
      if (cyc + 32'd2 >= 32'(m) && cyc <= 32'(m) + 32'd4) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_host_release;
    $fell(host_oe);
  endsequence
  sequence s_resp_start;
    $rose(dev_oe);
  endsequence

  chk_drive_only_low: assert property (dev_oe |-> !dev_out && resp_len < 32'(LOW_CYC + 2))
    else $error("sensor drives the wire high");
  chk_quiet_after_reset: assert property (@(posedge mclk_i) disable iff (1'b0) reset_i |=> !dev_oe && !host_oe)
    else $error("wire driven just after reset");
  chk_resp_after_release: assert property (s_resp_start |-> !host_oe && since_trig > 32'(START_CYC))
    else $error("sensor answered before the host released the wire");
  chk_delay_from_fall: assert property (s_resp_start |-> delay_ok(since_trig))
    else $error("response delay is not a legal multiplier times temperature");
  chk_resp_low_time: assert property ($fell(dev_oe) |-> resp_len + 32'd2 >= 32'(LOW_CYC) && resp_len <= 32'(LOW_CYC + 2))
    else $error("response low time is wrong");
  chk_start_min_len: assert property (s_host_release |-> pulse_len >= 32'(START_CYC))
    else $error("host start pulse too short");
  chk_start_max_len: assert property (s_host_release |-> pulse_len <= 32'(START_MAX_CYC) || pulse_len >= 32'(RST_CYC))
    else $error("host start pulse too long");
  chk_setup_before: assert property (s_host_release |-> setup_seen >= 32'(SETUP_CYC) || pulse_len >= 32'(RST_CYC))
    else $error("wire not high long enough before start");
  chk_forced_silent: assert property (s_host_release ##0 (pulse_len >= 32'(RST_CYC)) |=> !dev_oe [*8])
    else $error("sensor drives the wire after a forced return to ready");
endmodule

// File: test/tb_top.sv
// Self-checking bench: host and sensor ends joined on one wire, with the link checker beside it.
module tb_top
  import temp_delay_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int T_K   = 1;     // Low kelvin keeps the long delays within the run budget.
  localparam int RST_P = 2000;
  localparam logic [MULT_W-1:0] LOW_MULT [4] = '{10'h005, 10'h014, 10'h028, 10'h050};

  logic              mclk_i;
  logic              reset_i;
  logic              start_i;
  logic              force_ready_i;
  logic              high_range_i;
  logic              delay_select_msb_i;
  logic              delay_select_lsb_i;
  logic [TEMP_W-1:0] temp_kelvin_i;
  logic              busy_o;
  logic              done_o;
  logic              timeout_o;
  logic [US_W-1:0]   delay_us_o;
  logic [15:0]       temp_c_x100_o;
  logic              ready_o;
  int                mismatches;
  int                n_compared;
  int                cycles;

  // ==========================================================================
  // Both ends on one wire
  // ==========================================================================
  temp_wire_if wire_link ();

  // The sensor needs less low time than the host gives, so a host reset always lands.
  temp_delay_sensor #(.RESET_CYC_P(1800), .READY_CYC_P(34000)) i_temp_delay_sensor (
    .mclk_i(mclk_i), .reset_i(reset_i), .wire_if(wire_link.device), .temp_kelvin_i(temp_kelvin_i),
    .high_range_i(high_range_i), .delay_select_msb_i(delay_select_msb_i),
    .delay_select_lsb_i(delay_select_lsb_i), .ready_o(ready_o));

  temp_delay_host #(.RESET_CYC_P(RST_P), .READY_US_P(200)) i_temp_delay_host (
    .mclk_i(mclk_i), .reset_i(reset_i), .wire_if(wire_link.host), .start_i(start_i),
    .force_ready_i(force_ready_i), .high_range_i(high_range_i), .delay_select_msb_i(delay_select_msb_i),
    .delay_select_lsb_i(delay_select_lsb_i), .busy_o(busy_o), .done_o(done_o), .timeout_o(timeout_o),
    .delay_us_o(delay_us_o), .temp_c_x100_o(temp_c_x100_o));

  temp_wire_sva #(.T_K(T_K), .RST_CYC(RST_P)) i_temp_wire_sva (
    .mclk_i(mclk_i), .reset_i(reset_i), .dev_out(wire_link.dev_out), .dev_oe(wire_link.dev_oe),
    .host_out(wire_link.host_out), .host_oe(wire_link.host_oe), .line(wire_link.line));

  // ==========================================================================
  // Clock, watchdog and tasks
  // ==========================================================================
  always #2.5 mclk_i = ~mclk_i;

  // Cuts a hang short; the full run needs roughly 89,000 cycles.
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits at falling edges, where outputs are settled, for done, wire high or ready.
  task automatic wait_for(input int sel, input int limit);
    int         n;
    logic [2:0] v;
    n = 0;
    v = 3'h0;
    while (v[sel] !== 1'b1 && n < limit) begin
      @(negedge mclk_i);
      v = {ready_o, wire_link.line, done_o};
      n++;
    end
    // A wait that runs out is a failure in its own right.
    check({31'h0, v[sel]}, 32'h1);
  endtask

  // One measurement; straps change only while the sensor is ready.
  task automatic measure(input logic hi, input logic [1:0] sel, input logic [MULT_W-1:0] mult);
    logic [15:0] t_exp;
    t_exp = 16'(T_K * 100 - KELVIN_X100);
    @(posedge mclk_i);
    high_range_i       <= hi;
    delay_select_msb_i <= sel[1];
    delay_select_lsb_i <= sel[0];
    start_i            <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    wait_for(0, 40000);
    check({31'h0, done_o}, 32'h1);
    check({12'h0, delay_us_o}, 32'(mult) * 32'(T_K));
    check({16'h0, temp_c_x100_o}, {16'h0, t_exp});
    check({31'h0, wire_link.line}, 32'h0);
    check({31'h0, busy_o}, 32'h0);
    check({31'h0, timeout_o}, 32'h0);
  endtask

  // Host holds the wire low long enough to force the sensor back to ready.
  task automatic reset_link();
    wait_for(1, 3000);
    check({31'h0, ready_o}, 32'h0);
    @(posedge mclk_i);
    force_ready_i <= 1'b1;
    @(posedge mclk_i);
    force_ready_i <= 1'b0;
    wait_for(0, 4000);
    check({31'h0, ready_o}, 32'h1);
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    mclk_i             = 1'b0;
    reset_i            = 1'b1;
    start_i            = 1'b0;
    force_ready_i      = 1'b0;
    high_range_i       = 1'b0;
    delay_select_msb_i = 1'b0;
    delay_select_lsb_i = 1'b0;
    temp_kelvin_i      = 9'(T_K);
    mismatches         = 0;
    n_compared         = 0;
    cycles             = 0;
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(negedge mclk_i);
    check({31'h0, ready_o}, 32'h1);
    check({31'h0, wire_link.line}, 32'h1);
    // Every low-range strap code, each followed by a forced return to ready.
    for (int i = 0; i < 4; i++) begin
      measure(1'b0, 2'(i), LOW_MULT[i]);
      reset_link();
    end
    // High range, then the sensor must come back to ready on its own.
    measure(1'b1, 2'h0, 10'h0a0);
    check({31'h0, ready_o}, 32'h0);
    wait_for(2, 6000);
    check({31'h0, ready_o}, 32'h1);
    measure(1'b0, 2'h0, 10'h005);
    wait_for(1, 3000);
    print_verdict();
  end
endmodule
